// [src/edge_line_pkg.sv]
// Package: register map, reset values and widths for the edge line controller
package edge_line_pkg;
    localparam int LINE_COUNT = 19;
    localparam int GPIO_LINES = 16;
    localparam int LINE_VOLTAGE = 16;
    localparam int LINE_ALARM = 17;
    localparam int SEL_WIDTH = 4;
    localparam int PORT_COUNT = 5;
    localparam logic [SEL_WIDTH-1:0] SEL_PORT_A = 4'h0;
    localparam logic [SEL_WIDTH-1:0] SEL_PORT_E = 4'h4;
    localparam logic [11:0] OFF_INT_MASK = 12'h000;
    localparam logic [11:0] OFF_EVT_MASK = 12'h004;
    localparam logic [11:0] OFF_RISE_EN = 12'h008;
    localparam logic [11:0] OFF_FALL_EN = 12'h00C;
    localparam logic [11:0] OFF_SOFT_TRIG = 12'h010;
    localparam logic [11:0] OFF_PENDING = 12'h014;
    localparam logic [18:0] REG_RESET = 19'h00000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/edge_line_controller.sv]
// Edge-detecting interrupt and event controller with an AXI4-Lite register bank
// How it works
// - Enabled edge on interrupt-unmasked line raises request and sets pending flag.
// - Writing one to a pending bit clears it; zero leaves it.
// - Enabled edge on event-unmasked line pulses event output, no pending flag.
// - With interrupt mask set, writing one to a clear soft trigger sets pending.
// - Soft trigger bit stays set until its pending flag is cleared.
// - Interrupt mask bit zero blocks the line request, one passes it.
// - Event mask bit zero blocks the event, one allows the pulse.
// - Rising enable makes rising edges trigger both interrupt and event paths.
// - Falling enable makes falling edges trigger both interrupt and event paths.
// - Both enables set: either transition triggers.
// - Rising edge during a rising-enable write does not set pending.
// - Falling edge during a falling-enable write does not set pending.
// - Pending reads zero until a trigger, then one until cleared.
// - Bits 31 to 19 of every register read as zero.
// - Line 16 is voltage detector output, line 17 the alarm event.
// - Lines 0 to 15 each come from the same-numbered pin of a port.
// - A 4-bit selector per line picks port A (0) to port E (4).
// - Event mode wakes the core and leaves no pending flag.
// - All six registers reset to zero.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module edge_line_controller #(
    parameter int LINES = edge_line_pkg::LINE_COUNT
) (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    // Pin groups: port A..E, one bit per pin number
    input wire logic [edge_line_pkg::GPIO_LINES-1:0] I_PORT_A,
    input wire logic [edge_line_pkg::GPIO_LINES-1:0] I_PORT_B,
    input wire logic [edge_line_pkg::GPIO_LINES-1:0] I_PORT_C,
    input wire logic [edge_line_pkg::GPIO_LINES-1:0] I_PORT_D,
    input wire logic [edge_line_pkg::GPIO_LINES-1:0] I_PORT_E,
    input wire logic [edge_line_pkg::GPIO_LINES*edge_line_pkg::SEL_WIDTH-1:0] I_PIN_LINE_SELECTOR,
    input wire logic I_VOLTAGE_DETECTOR_OUTPUT,
    input wire logic I_ALARM_EVENT,
    input wire logic I_LINE_18,
    output logic [LINES-1:0] O_LINE_IRQ,
    output logic O_WAKE_EVENT,
    // AXI4-Lite slave
    input wire logic [11:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [11:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY
);

    // ****************************************
    // Line source selection
    // ****************************************
    // Codes above port E select nothing, so a misprogrammed line stays quiet
    function automatic logic pick_pin(input logic [edge_line_pkg::SEL_WIDTH-1:0] sel,
                                      input logic [edge_line_pkg::PORT_COUNT-1:0] pins);
        logic r;
        r = 1'b0;
        if (sel <= edge_line_pkg::SEL_PORT_E) begin
            r = pins[sel[2:0]];
        end
        return r;
    endfunction

    logic [LINES-1:0] raw_line;
    genvar g;
    generate
        for (g = 0; g < edge_line_pkg::GPIO_LINES; g++) begin : g_pin
            assign raw_line[g] = pick_pin(I_PIN_LINE_SELECTOR[g*edge_line_pkg::SEL_WIDTH +: edge_line_pkg::SEL_WIDTH],
                {I_PORT_E[g], I_PORT_D[g], I_PORT_C[g], I_PORT_B[g], I_PORT_A[g]});
        end
    endgenerate
    assign raw_line[edge_line_pkg::LINE_VOLTAGE] = I_VOLTAGE_DETECTOR_OUTPUT;
    assign raw_line[edge_line_pkg::LINE_ALARM] = I_ALARM_EVENT;
    assign raw_line[LINES-1] = I_LINE_18;

    // ****************************************
    // Edge detection
    // ****************************************
    logic [LINES-1:0] sample;
    logic [LINES-1:0] last;
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sample <= '0;
            last <= '0;
        end else begin
            sample <= raw_line;
            last <= sample;
        end
    end

    // ****************************************
    // Register bank
    // ****************************************
    logic [LINES-1:0] int_mask;
    logic [LINES-1:0] evt_mask;
    logic [LINES-1:0] rise_en;
    logic [LINES-1:0] fall_en;
    logic [LINES-1:0] soft_trig;
    logic [LINES-1:0] pending;

    // Write channel: address and data may arrive in either order
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [LINES-1:0] wr_val;
    assign wr_fire = aw_held && w_held && !O_BVALID;
    always_comb begin
        wr_val = '0;
        for (int i = 0; i < LINES; i++) begin
            if (w_strb[i/8]) begin
                wr_val[i] = w_data[i];
            end
        end
    end

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return a[11:2] <= edge_line_pkg::OFF_PENDING[11:2];
    endfunction

    logic wr_rise;
    logic wr_fall;
    logic wr_soft;
    logic wr_pend;
    assign wr_rise = wr_fire && hit(aw_addr, edge_line_pkg::OFF_RISE_EN);
    assign wr_fall = wr_fire && hit(aw_addr, edge_line_pkg::OFF_FALL_EN);
    assign wr_soft = wr_fire && hit(aw_addr, edge_line_pkg::OFF_SOFT_TRIG);
    assign wr_pend = wr_fire && hit(aw_addr, edge_line_pkg::OFF_PENDING);

    // Byte lanes: only lanes with strobe can change; others keep old bits
    function automatic logic [LINES-1:0] merge(input logic [LINES-1:0] old, input logic [LINES-1:0] nv,
                                               input logic [3:0] st);
        logic [LINES-1:0] r;
        r = old;
        for (int i = 0; i < LINES; i++) begin
            if (st[i/8]) begin
                r[i] = nv[i];
            end
        end
        return r;
    endfunction

    logic [LINES-1:0] rise_hit;
    logic [LINES-1:0] fall_hit;
    logic [LINES-1:0] trig;
    // An edge coinciding with a write to its enable register is dropped
    assign rise_hit = sample & ~last & rise_en & ~(wr_rise ? {LINES{1'b1}} : '0);
    assign fall_hit = ~sample & last & fall_en & ~(wr_fall ? {LINES{1'b1}} : '0);
    assign trig = rise_hit | fall_hit;

    logic [LINES-1:0] soft_set;
    assign soft_set = wr_soft ? (wr_val & ~soft_trig & int_mask) : '0;
    logic [LINES-1:0] pend_clr;
    assign pend_clr = wr_pend ? wr_val : '0;

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            int_mask <= edge_line_pkg::REG_RESET;
            evt_mask <= edge_line_pkg::REG_RESET;
            rise_en <= edge_line_pkg::REG_RESET;
            fall_en <= edge_line_pkg::REG_RESET;
        end else if (wr_fire) begin
            if (hit(aw_addr, edge_line_pkg::OFF_INT_MASK)) begin
                int_mask <= merge(int_mask, wr_val, w_strb);
            end
            if (hit(aw_addr, edge_line_pkg::OFF_EVT_MASK)) begin
                evt_mask <= merge(evt_mask, wr_val, w_strb);
            end
            if (wr_rise) begin
                rise_en <= merge(rise_en, wr_val, w_strb);
            end
            if (wr_fall) begin
                fall_en <= merge(fall_en, wr_val, w_strb);
            end
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            pending <= edge_line_pkg::REG_RESET;
        end else begin
            pending <= (pending & ~pend_clr) | (trig & int_mask) | soft_set;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            soft_trig <= edge_line_pkg::REG_RESET;
        end else begin
            soft_trig <= (soft_trig & ~pend_clr) | soft_set;
        end
    end

    // ****************************************
    // Outputs to the core
    // ****************************************
    logic [LINES-1:0] evt_soft;
    assign evt_soft = wr_soft ? (wr_val & ~soft_trig & evt_mask) : '0;
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_LINE_IRQ <= '0;
            O_WAKE_EVENT <= 1'b0;
        end else begin
            O_LINE_IRQ <= ((pending & ~pend_clr) | (trig & int_mask) | soft_set) & int_mask;
            // Event path never touches pending, so nothing to clear after wake-up
            O_WAKE_EVENT <= |((trig & evt_mask) | evt_soft);
        end
    end

    // ****************************************
    // AXI4-Lite handshakes
    // ****************************************
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            O_AWREADY <= 1'b1;
        end else if (I_AWVALID && O_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= I_AWADDR;
            O_AWREADY <= 1'b0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !O_BVALID) begin
            // Reopen only after the response is taken, so one write is under way at a time
            O_AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            O_WREADY <= 1'b1;
        end else if (I_WVALID && O_WREADY) begin
            w_held <= 1'b1;
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
            O_WREADY <= 1'b0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (!w_held && !O_BVALID) begin
            O_WREADY <= 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_BVALID <= 1'b0;
            O_BRESP <= edge_line_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            O_BVALID <= 1'b1;
            O_BRESP <= mapped(aw_addr) ? edge_line_pkg::RESP_OKAY : edge_line_pkg::RESP_SLVERR;
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    function automatic logic [31:0] read_word(input logic [11:0] a, input logic [LINES-1:0] im,
        input logic [LINES-1:0] em, input logic [LINES-1:0] re, input logic [LINES-1:0] fe,
        input logic [LINES-1:0] st, input logic [LINES-1:0] pd);
        logic [31:0] r;
        r = '0;
        if (hit(a, edge_line_pkg::OFF_INT_MASK)) r[LINES-1:0] = im;
        if (hit(a, edge_line_pkg::OFF_EVT_MASK)) r[LINES-1:0] = em;
        if (hit(a, edge_line_pkg::OFF_RISE_EN)) r[LINES-1:0] = re;
        if (hit(a, edge_line_pkg::OFF_FALL_EN)) r[LINES-1:0] = fe;
        if (hit(a, edge_line_pkg::OFF_SOFT_TRIG)) r[LINES-1:0] = st;
        if (hit(a, edge_line_pkg::OFF_PENDING)) r[LINES-1:0] = pd;
        return r;
    endfunction

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_ARREADY <= 1'b1;
            O_RVALID <= 1'b0;
            O_RDATA <= '0;
            O_RRESP <= edge_line_pkg::RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= read_word(I_ARADDR, int_mask, evt_mask, rise_en, fall_en, soft_trig, pending);
            O_RRESP <= mapped(I_ARADDR) ? edge_line_pkg::RESP_OKAY : edge_line_pkg::RESP_SLVERR;
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID <= 1'b0;
            O_ARREADY <= 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_pend_on_edge: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (trig[0] && int_mask[0]) |=> pending[0]) else $error("edge did not set pending");
    a_pend_clear: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (pend_clr[0] && !trig[0] && !soft_set[0]) |=> !pending[0]) else $error("pending not cleared");
    a_event_no_pend: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (trig[2] && evt_mask[2] && !int_mask[2] && !pending[2] && !soft_set[2]) |=> (O_WAKE_EVENT && !pending[2]))
        else $error("event path misbehaved");
    a_soft_sets: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        soft_set[4] |=> (pending[4] && soft_trig[4])) else $error("soft trigger did not set pending");
    a_soft_hold: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (soft_trig[4] && !pend_clr[4]) |=> soft_trig[4]) else $error("soft trigger dropped");
    a_irq_masked: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (!int_mask[3] && !$past(int_mask[3])) |-> !O_LINE_IRQ[3]) else $error("masked line raised irq");
    a_rise_blocked: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (wr_rise && !fall_hit[4] && !soft_set[4] && !pending[4]) |=> !pending[4]) else $error("edge during write");
    a_irq_follows: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        $rose(pending[5]) |-> O_LINE_IRQ[5]) else $error("irq not tied to pending");
    a_rdata_reserved: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        O_RVALID |-> (O_RDATA[31:19] == 13'h0000)) else $error("reserved bits nonzero");
    a_edge_once: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        rise_hit[0] |=> !rise_hit[0]) else $error("edge triggered twice");
    // Each check watches a line that the tests toggle or soft-trigger, so none sits idle
    a_rise_trig: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (sample[0] && !last[0] && rise_en[0] && !wr_rise && int_mask[0]) |=> pending[0])
        else $error("rising edge missed");
    a_fall_trig: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (!sample[16] && last[16] && fall_en[16] && !wr_fall && int_mask[16]) |=> pending[16])
        else $error("falling edge missed");
    a_both_edges: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        ((sample[17] != last[17]) && rise_en[17] && fall_en[17] && !wr_rise && !wr_fall) |-> trig[17])
        else $error("transition not a trigger");
    a_fall_blocked: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (wr_fall && !rise_hit[4] && !soft_set[4] && !pending[4]) |=> !pending[4])
        else $error("edge during write");
    a_event_masked: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (((trig & evt_mask) | evt_soft) == '0) |=> !O_WAKE_EVENT)
        else $error("masked event pulsed");
    a_soft_event: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (evt_soft[2] && !int_mask[2] && !pending[2]) |=> (O_WAKE_EVENT && !pending[2]))
        else $error("soft event misbehaved");
    a_soft_masked: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (wr_soft && wr_val[3] && !int_mask[3] && !pending[3]) |=> !pending[3])
        else $error("masked soft trigger set pending");
    a_soft_clear: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (pend_clr[4] && !soft_set[4]) |=> !soft_trig[4])
        else $error("soft trigger not cleared");
    a_pend_hold: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (pending[0] && !pend_clr[0]) |=> pending[0])
        else $error("pending dropped");
    a_write_zero: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (wr_pend && !wr_val[5] && pending[5]) |=> pending[5])
        else $error("zero write cleared pending");
    a_irq_drop: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        (pend_clr[0] && !trig[0] && !soft_set[0]) |=> !O_LINE_IRQ[0])
        else $error("irq outlived pending");
endmodule

`default_nettype wire

// [testbench/line_source_model.sv]
// Line source model: drives pin groups and internal line sources
`timescale 1ns/1ps
`default_nettype none
module line_source_model (
    input wire logic [18:0] i_level,
    input wire logic [63:0] i_sel,
    output logic [15:0] o_port_a,
    output logic [15:0] o_port_b,
    output logic [15:0] o_port_c,
    output logic [15:0] o_port_d,
    output logic [15:0] o_port_e,
    output logic o_voltage,
    output logic o_alarm,
    output logic o_line_18
);
    // Unselected pins carry the inverse level, so a wrong port choice shows as the wrong edge
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            o_port_a[n] = (i_sel[4*n +: 4] == 4'h0) ? i_level[n] : ~i_level[n];
            o_port_b[n] = (i_sel[4*n +: 4] == 4'h1) ? i_level[n] : ~i_level[n];
            o_port_c[n] = (i_sel[4*n +: 4] == 4'h2) ? i_level[n] : ~i_level[n];
            o_port_d[n] = (i_sel[4*n +: 4] == 4'h3) ? i_level[n] : ~i_level[n];
            o_port_e[n] = (i_sel[4*n +: 4] == 4'h4) ? i_level[n] : ~i_level[n];
        end
    end
    assign o_voltage = i_level[16];
    assign o_alarm = i_level[17];
    assign o_line_18 = i_level[18];
endmodule
`default_nettype wire

// [testbench/edge_line_controller_tb_top.sv]
// Testbench: register bus tasks and line stimulus for the edge line controller
`timescale 1ns/1ps
`default_nettype none
module edge_line_controller_tb_top;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready, wake;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [18:0] lv, irq;
    logic [63:0] sel;
    logic [15:0] pa, pb, pc, pd, pe;
    logic vd, al, l18;
    logic [7:0] wake_cnt, wc0;
    int error_cnt = 0;
    int compares = 0;
    localparam logic [1:0] OK = edge_line_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = edge_line_pkg::RESP_SLVERR;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    line_source_model i_line_source_model (.i_level(lv), .i_sel(sel), .o_port_a(pa), .o_port_b(pb),
        .o_port_c(pc), .o_port_d(pd), .o_port_e(pe), .o_voltage(vd), .o_alarm(al), .o_line_18(l18));
    edge_line_controller i_edge_line_controller (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PORT_A(pa),
        .I_PORT_B(pb), .I_PORT_C(pc), .I_PORT_D(pd), .I_PORT_E(pe), .I_PIN_LINE_SELECTOR(sel),
        .I_VOLTAGE_DETECTOR_OUTPUT(vd), .I_ALARM_EVENT(al), .I_LINE_18(l18), .O_LINE_IRQ(irq),
        .O_WAKE_EVENT(wake), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
    // A level instead of a pulse counts once per cycle and shows up here
    always @(posedge clk) begin
        if (rst)
            wake_cnt <= 8'h00;
        else if (wake === 1'b1)
            wake_cnt <= wake_cnt + 8'h01;
    end
    // **********
    // Tasks
    // **********
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                            input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task automatic set_lines(input logic [18:0] v);
        @(posedge clk);
        lv <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // **********
    // Sequence
    // **********
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        lv = 19'h0;
        sel = 64'h0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) axi_read(12'(4 * i), 32'h0, '1, OK);
        chk("irq", 32'h0, {13'h0, irq});
        axi_read(12'h018, 32'h0, '1, ERR);
        axi_write(12'h018, 32'hFFFFFFFF, ERR);
        axi_write(edge_line_pkg::OFF_INT_MASK, 32'hFFFFFFFF, OK);
        axi_read(edge_line_pkg::OFF_INT_MASK, 32'h0007FFFF, '1, OK);
        sel[23:20] <= edge_line_pkg::SEL_PORT_E;
        axi_write(edge_line_pkg::OFF_INT_MASK, 32'h00030031, OK);
        axi_write(edge_line_pkg::OFF_EVT_MASK, 32'h00000004, OK);
        axi_write(edge_line_pkg::OFF_RISE_EN, 32'h00020025, OK);
        axi_write(edge_line_pkg::OFF_FALL_EN, 32'h00030002, OK);
        wc0 = wake_cnt;
        set_lines(19'h30027);
        chk("irq", 32'h00020021, {13'h0, irq});
        chk("wake", {24'h0, wc0 + 8'h01}, {24'h0, wake_cnt});
        axi_read(edge_line_pkg::OFF_PENDING, 32'h00020021, 32'h7FFFD, OK);
        axi_write(edge_line_pkg::OFF_PENDING, 32'h00020000, OK);
        set_lines(19'h00000);
        chk("irq", 32'h00030021, {13'h0, irq});
        chk("wake", {24'h0, wc0 + 8'h01}, {24'h0, wake_cnt});
        axi_write(edge_line_pkg::OFF_PENDING, 32'h0, OK);
        axi_read(edge_line_pkg::OFF_PENDING, 32'h00030021, 32'h7FFFD, OK);
        axi_write(edge_line_pkg::OFF_PENDING, 32'h0007FFFF, OK);
        axi_read(edge_line_pkg::OFF_PENDING, 32'h0, '1, OK);
        chk("irq", 32'h0, {13'h0, irq});
        axi_write(edge_line_pkg::OFF_SOFT_TRIG, 32'h00000018, OK);
        axi_read(edge_line_pkg::OFF_PENDING, 32'h00000010, '1, OK);
        axi_read(edge_line_pkg::OFF_SOFT_TRIG, 32'h00000010, 32'h10, OK);
        chk("irq", 32'h00000010, {13'h0, irq});
        axi_write(edge_line_pkg::OFF_PENDING, 32'h00000010, OK);
        axi_read(edge_line_pkg::OFF_SOFT_TRIG, 32'h0, 32'h10, OK);
        axi_read(edge_line_pkg::OFF_PENDING, 32'h0, '1, OK);
        // Soft trigger on an event-only line: one wake pulse, nothing pending
        axi_write(edge_line_pkg::OFF_SOFT_TRIG, 32'h00000004, OK);
        axi_read(edge_line_pkg::OFF_PENDING, 32'h0, '1, OK);
        chk("wake", {24'h0, wc0 + 8'h02}, {24'h0, wake_cnt});
        axi_read(edge_line_pkg::OFF_SOFT_TRIG, 32'h0, '1, OK);
        // Line 4 already enabled; its edge lands in the cycle the same enable is rewritten
        axi_write(edge_line_pkg::OFF_RISE_EN, 32'h00020035, OK);
        axi_write(edge_line_pkg::OFF_FALL_EN, 32'h00030012, OK);
        fork
            axi_write(edge_line_pkg::OFF_RISE_EN, 32'h00020035, OK);
            begin
                @(posedge clk);
                lv <= 19'h00010;
            end
        join
        fork
            axi_write(edge_line_pkg::OFF_FALL_EN, 32'h00030012, OK);
            begin
                @(posedge clk);
                lv <= 19'h00000;
            end
        join
        axi_read(edge_line_pkg::OFF_PENDING, 32'h0, '1, OK);
        chk("irq", 32'h0, {13'h0, irq});
        tally_and_finish();
    end
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
